// ---- rtl/eedp_ctrl.sv ----
// data eeprom access controller with page buffer
//
// Notes on behaviour
// [R1] software erases a page before writing it
// [R2] mode one gives page ops, zero byte
// [R3] power-on reset clears the page buffer
// [R4] enable falling clears buffer, rising keeps it
// [R5] address: page upper five, offset lower four
// [R6] page data write loads buffer, bumps offset
// [R7] offset stops at F, later writes ignored
// [R8] strobe counts only right after enable set
// [R9] strobe without write enable starts nothing
// [R10] cycle timed by asynchronous internal timer
// [R11] write strobe clears when cycle ends
// [R12] write enable clears after the write
// [R13] write enable is zero after power-on
// [R14] pointer high bytes reset to sector zero
// [R15] cycle end raises the interrupt flag
// [R16] vector needs both enables, stack not full
// [R17] servicing the interrupt clears its flag
// [R18] software sets erase strobe right after enable
// [R19] software masks interrupts around activation
// [R20] software avoids sleep during an operation
// [R21] read needs enable; strobe clears on data
// [R22] control reached at 40H in sector 01H
// [R23] byte write erases the byte first
// [R24] erased page bytes read back zero
// [R25] page read bumps offset, stops at F
// [R26] slow clock brought in sync, then its edges counted
`timescale 1ns/100ps
module eedp_ctrl import eedp_pkg::*; #(
	parameter int TICKS = PROG_TICKS
) (
	// system
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic slow_clk,
	// memory pointers and indirect access
	input wire logic ptr1_high_wr,
	input wire logic ptr2_high_wr,
	input wire logic [7:0] ptr_wdata,
	input wire logic [7:0] pointer1_low_byte,
	input wire logic [7:0] ptr2_low_byte,
	input wire logic ind_wr,
	input wire logic ind_sel,
	input wire logic [7:0] ind_wdata,
	// direct register writes
	input wire logic addr_high_wr,
	input wire logic addr_low_wr,
	input wire logic data_wr,
	input wire logic [7:0] reg_wdata,
	// interrupt context
	input wire logic global_irq_enable,
	input wire logic eeprom_irq_enable,
	input wire logic stack_full,
	input wire logic irq_service,
	// register views
	output logic [7:0] pointer1_high_byte,
	output logic [7:0] pointer2_high_byte,
	output eedp_ctl_t eeprom_control_reg,
	output logic eeprom_addr_high_reg,
	output logic [7:0] eeprom_addr_low_reg,
	output logic [7:0] eeprom_data_reg,
	output logic eeprom_irq_flag,
	output logic irq_request
);
	function automatic logic hits_ctl(input logic [7:0] hi,
		input logic [7:0] lo);
		return (hi == CTL_SECTOR) && (lo == CTL_OFFSET); // [R22]
	endfunction

	eedp_state_t st, next_st;
	eedp_ctl_t ctl, next_ctl, w;
	eedp_mem_wr_t mem_cmd;
	logic [7:0] buf_q [PAGE_BYTES];
	logic [7:0] next_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] tag, next_tag;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [OFS_W-1:0] idx, next_idx;
	logic [7:0] data, next_data, p1h, p2h, next_p1h, next_p2h, rdata;
	logic [1:0] rcnt, next_rcnt;
	logic stop, next_stop, wr_arm, er_arm, next_wr_arm, next_er_arm;
	logic flag, next_flag, req, next_req, ctl_wr, t_start, t_done, fin;
	logic [OFS_W-1:0] ofs;

	assign ofs = addr[OFS_W-1:0]; // [R5]
	assign w = ind_wdata;
	assign ctl_wr = ind_wr && (ind_sel ? hits_ctl(p2h, ptr2_low_byte)
		: hits_ctl(p1h, pointer1_low_byte));

	eedp_prog_timer #(
		.TICKS(TICKS)
	) u_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(t_start),
		.slow_clk(slow_clk),
		.done(t_done)
	);

	eedp_array u_array (
		.clk_sys(clk_sys),
		.rd_addr(addr),
		.wr(mem_cmd),
		.rd_data(rdata)
	);

	always_comb begin
		next_st = st;
		next_ctl = ctl;
		next_buf = buf_q;
		next_tag = tag;
		next_addr = addr;
		next_idx = idx;
		next_data = data;
		next_rcnt = rcnt;
		next_stop = stop;
		next_p1h = ptr1_high_wr ? ptr_wdata : p1h;
		next_p2h = ptr2_high_wr ? ptr_wdata : p2h;
		next_wr_arm = 1'b0;
		next_er_arm = 1'b0;
		mem_cmd = '0;
		t_start = 1'b0;
		fin = 1'b0;
		case (st)
			ST_IDLE: begin
				// control, address and data registers are frozen while an operation runs
				if (ctl_wr) begin
					next_ctl.mode = w.mode;
					next_ctl.read_enable_bit = w.read_enable_bit;
					next_ctl.write_enable_bit = w.write_enable_bit;
					next_ctl.erase_enable_bit = w.erase_enable_bit;
					next_wr_arm = w.write_enable_bit && !ctl.write_enable_bit;
					next_er_arm = w.erase_enable_bit && !ctl.erase_enable_bit;
					if (w.write_strobe_bit && wr_arm && w.write_enable_bit) begin
						next_ctl.write_strobe_bit = 1'b1; // [R8] [R9]
						next_st = ST_WAIT;
						t_start = 1'b1; // [R10]
						if (!ctl.mode) begin
							mem_cmd = '{1'b1, addr, BYTE_ZERO}; // [R23]
						end
					end else if (w.erase_strobe_bit && er_arm
						&& w.erase_enable_bit) begin
						next_ctl.erase_strobe_bit = 1'b1; // [R8]
						next_st = ST_WAIT;
						t_start = 1'b1;
					end else if (w.read_strobe_bit && ctl.read_enable_bit
						&& w.read_enable_bit) begin
						next_ctl.read_strobe_bit = 1'b1; // [R21]
						next_rcnt = 2'(READ_CYCLES);
						next_st = ST_READ;
					end
				end
				if (addr_high_wr) begin
					next_addr[ADDR_W-1] = reg_wdata[0];
				end
				if (addr_low_wr) begin
					next_addr[7:0] = reg_wdata;
					next_stop = 1'b0;
				end
				if (data_wr) begin
					next_data = reg_wdata;
					if (ctl.mode && !stop) begin // [R2]
						next_buf[ofs] = reg_wdata; // [R6]
						next_tag[ofs] = 1'b1;
						if (ofs == OFS_LAST) begin
							next_stop = 1'b1; // [R7]
						end else begin
							next_addr[OFS_W-1:0] = ofs + 1'b1; // [R6]
						end
					end
				end
			end
			ST_READ: begin
				next_rcnt = rcnt - 1'b1;
				if (rcnt == 2'(1)) begin
					next_data = rdata;
					next_ctl.read_strobe_bit = 1'b0; // [R21]
					next_st = ST_IDLE;
					if (ctl.mode && ofs != OFS_LAST) begin
						next_addr[OFS_W-1:0] = ofs + 1'b1; // [R25]
					end
				end
			end
			ST_WAIT: begin
				if (t_done) begin // [R26]
					if (ctl.mode) begin
						next_idx = '0;
						next_st = ST_COMMIT;
					end else begin
						mem_cmd = '{1'b1, addr,
							ctl.write_strobe_bit ? data : BYTE_ZERO};
						fin = 1'b1;
					end
				end
			end
			ST_COMMIT: begin
				// one tagged byte per cycle keeps a single write port
				mem_cmd = '{tag[idx], {addr[ADDR_W-1:OFS_W], idx},
					ctl.write_strobe_bit ? buf_q[idx] : BYTE_ZERO}; // [R24]
				next_idx = idx + 1'b1;
				fin = (idx == OFS_LAST);
			end
			default: begin
				next_st = ST_IDLE;
			end
		endcase
		if (fin) begin
			next_ctl.write_strobe_bit = 1'b0; // [R11]
			next_ctl.erase_strobe_bit = 1'b0;
			next_ctl.write_enable_bit = 1'b0; // [R12]
			next_ctl.erase_enable_bit = 1'b0;
			next_st = ST_IDLE;
		end
		if ((ctl.write_enable_bit && !next_ctl.write_enable_bit)
			|| (ctl.erase_enable_bit && !next_ctl.erase_enable_bit)) begin
			next_tag = '0; // [R4]
			next_stop = 1'b0;
		end
	end

	// set wins over the service clear
	always_comb begin
		next_flag = flag;
		if (irq_service) begin
			next_flag = 1'b0; // [R17]
		end
		if (fin) begin
			next_flag = 1'b1; // [R15]
		end
		next_req = flag && eeprom_irq_enable && global_irq_enable
			&& !stack_full && !irq_service; // [R16]
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= ST_IDLE;
			ctl <= CTL_RESET; // [R13]
			tag <= '0; // [R3]
			addr <= '0;
			idx <= '0;
			data <= '0;
			rcnt <= '0;
			stop <= 1'b0;
			p1h <= PTR_RESET; // [R14]
			p2h <= PTR_RESET;
			wr_arm <= 1'b0;
			er_arm <= 1'b0;
			flag <= 1'b0;
			req <= 1'b0;
		end else begin
			st <= next_st;
			ctl <= next_ctl;
			tag <= next_tag;
			addr <= next_addr;
			idx <= next_idx;
			data <= next_data;
			rcnt <= next_rcnt;
			stop <= next_stop;
			p1h <= next_p1h;
			p2h <= next_p2h;
			wr_arm <= next_wr_arm;
			er_arm <= next_er_arm;
			flag <= next_flag;
			req <= next_req;
		end
	end

	// untagged bytes are never committed, so buffer data needs no reset
	always_ff @(posedge clk_sys) begin
		buf_q <= next_buf;
	end

	assign pointer1_high_byte = p1h;
	assign pointer2_high_byte = p2h;
	assign eeprom_control_reg = ctl;
	assign eeprom_addr_high_reg = addr[ADDR_W-1];
	assign eeprom_addr_low_reg = addr[7:0];
	assign eeprom_data_reg = data;
	assign eeprom_irq_flag = flag;
	assign irq_request = req;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	strobe_unarmed_a: assert property ( // [R8]
		st == ST_IDLE && ctl_wr && w.write_strobe_bit && !wr_arm
		|=> !ctl.write_strobe_bit)
		else $error("write strobe taken without arming");
	strobe_needs_en_a: assert property ( // [R9]
		ctl.write_strobe_bit |-> ctl.write_enable_bit)
		else $error("write strobe set without write enable");
	buf_clear_a: assert property ( // [R4]
		$fell(ctl.write_enable_bit) |-> tag == '0)
		else $error("buffer tags survive enable fall");
	ofs_hold_a: assert property ( // [R7]
		st == ST_IDLE && stop && data_wr && !addr_low_wr
		|=> $stable(ofs) && $stable(tag))
		else $error("write past offset F accepted");
	page_fixed_a: assert property ( // [R6]
		st == ST_IDLE && ctl.mode && data_wr && !addr_high_wr
		&& !addr_low_wr |=> $stable(addr[ADDR_W-1:OFS_W]))
		else $error("page number moved on data write");
	cycle_end_a: assert property ( // [R12]
		$fell(ctl.write_strobe_bit) |-> !ctl.write_enable_bit && flag)
		else $error("enable or flag wrong at cycle end");
	irq_gate_a: assert property ( // [R16]
		irq_request |-> $past(flag && eeprom_irq_enable
		&& global_irq_enable && !stack_full))
		else $error("interrupt requested without cause");
	svc_clear_a: assert property ( // [R17]
		irq_service && !fin |=> !flag)
		else $error("service left flag set");
	read_done_a: assert property ( // [R21]
		$rose(ctl.read_strobe_bit) |-> ##[1:3] !ctl.read_strobe_bit)
		else $error("read strobe not cleared");
	erase_zero_a: assert property ( // [R24]
		st == ST_COMMIT && ctl.erase_strobe_bit |-> mem_cmd.data == '0)
		else $error("page erase wrote nonzero");
	reset_state_a: assert property ( // [R14]
		$past(rst) |-> p1h == '0 && !ctl.write_enable_bit)
		else $error("reset values wrong");

	page_write_c: cover property (
		st == ST_COMMIT && ctl.write_strobe_bit && fin);
	page_erase_c: cover property (
		st == ST_COMMIT && ctl.erase_strobe_bit && fin);
	byte_write_c: cover property (
		st == ST_WAIT && !ctl.mode && fin);
	page_read_c: cover property ($fell(ctl.read_strobe_bit) && ctl.mode);
endmodule

// ---- rtl/eedp_pkg.sv ----
// shared constants and types of the data eeprom page controller
package eedp_pkg;
	localparam int ADDR_W = 9;
	localparam int OFS_W = 4;
	localparam int PAGE_W = 5;
	localparam int PAGE_BYTES = 16;
	localparam logic [OFS_W-1:0] OFS_LAST = 4'hF;
	localparam logic [7:0] CTL_OFFSET = 8'h40;
	localparam logic [7:0] CTL_SECTOR = 8'h01;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int READ_CYCLES = 2;
	localparam int PROG_TICKS = 64;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// bit 0 read strobe up to bit 6 erase enable
	typedef struct packed {
		logic rsvd;
		logic erase_enable_bit;
		logic erase_strobe_bit;
		logic mode;
		logic write_enable_bit;
		logic write_strobe_bit;
		logic read_enable_bit;
		logic read_strobe_bit;
	} eedp_ctl_t;

	typedef struct packed {
		logic en;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} eedp_mem_wr_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_READ = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_COMMIT = 4'b1000
	} eedp_state_t;
endpackage

// ---- rtl/eedp_prog_timer.sv ----
// program cycle timer counting edges of the slow asynchronous clock
`timescale 1ns/100ps
module eedp_prog_timer import eedp_pkg::*; #(
	parameter int TICKS = PROG_TICKS
) (
	// system
	input wire logic clk_sys,
	input wire logic rst,
	// control
	input wire logic start,
	input wire logic slow_clk,
	// completion
	output logic done
);
	localparam int CW = $clog2(TICKS + 1);
	logic s1, s2, s3, run, next_run, next_done;
	logic [CW-1:0] cnt, next_cnt;

	always_comb begin
		next_run = run;
		next_cnt = cnt;
		next_done = 1'b0;
		if (start) begin
			next_run = 1'b1;
			next_cnt = CW'(TICKS);
		end else if (run && s2 && !s3) begin
			next_cnt = cnt - 1'b1;
			if (cnt == CW'(1)) begin
				next_run = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	// s1 feeds only s2; edges seen on s2/s3
	always_ff @(posedge clk_sys) begin
		s1 <= slow_clk;
		s2 <= s1;
		if (rst) begin
			s3 <= 1'b0;
			run <= 1'b0;
			cnt <= '0;
			done <= 1'b0;
		end else begin
			s3 <= s2;
			run <= next_run;
			cnt <= next_cnt;
			done <= next_done;
		end
	end
endmodule

// ---- rtl/eedp_array.sv ----
// nonvolatile byte array held in flip-flops, registered read
`timescale 1ns/100ps
module eedp_array import eedp_pkg::*; (
	// system
	input wire logic clk_sys,
	// access
	input wire logic [ADDR_W-1:0] rd_addr,
	input eedp_mem_wr_t wr,
	output logic [7:0] rd_data
);
	logic [7:0] mem [2**ADDR_W];

	// contents survive reset on purpose
	always_ff @(posedge clk_sys) begin
		rd_data <= mem[rd_addr];
		if (wr.en) begin
			mem[wr.addr] <= wr.data;
		end
	end
endmodule

// ---- tb/eedp_core_model.sv ----
// processor core model issuing register writes to the eeprom controller
`timescale 1ns/100ps
module eedp_core_model import eedp_pkg::*; (
	// system
	input wire logic clk_sys,
	// register writes
	output logic ptr1_high_wr,
	output logic addr_high_wr,
	output logic addr_low_wr,
	output logic data_wr,
	output logic ind_wr,
	output logic [7:0] wdata,
	// interrupt context
	output logic global_irq_enable
);
	// core never enters a low power mode here
	initial begin
		{ind_wr, data_wr, addr_low_wr, addr_high_wr, ptr1_high_wr} = 5'h00;
		wdata = 8'h00;
		global_irq_enable = 1'b1;
	end
	// k: 0 pointer high, 1 addr high, 2 addr low, 3 data, 4 control, 5 none
	task automatic wr(input int k, input logic [7:0] v);
		@(negedge clk_sys);
		{ind_wr, data_wr, addr_low_wr, addr_high_wr, ptr1_high_wr} <= 5'h01 << k;
		wdata <= v;
	endtask
	// enable then strobe on back to back cycles, interrupts masked
	task automatic start(input logic [7:0] en, input logic [7:0] go);
		@(negedge clk_sys);
		global_irq_enable <= 1'b0;
		wr(4, en);
		wr(4, go);
		wr(5, 8'h00);
		global_irq_enable <= 1'b1;
	endtask
endmodule

// ---- tb/test_data_eeprom_page_write_ctrl.sv ----
// self-checking bench of the data eeprom page controller
`timescale 1ns/100ps
module test_data_eeprom_page_write_ctrl import eedp_pkg::*;;
	localparam int TK = 3;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic slow_clk = 1'b0;
	logic eie = 1'b1;
	logic stack_full = 1'b0;
	logic irq_service = 1'b0;
	logic p1w, ahw, alw, dw, iw, gie, ahr, irq_flag, irq_req;
	logic [7:0] wd, p1h, p2hb, al, dat;
	eedp_ctl_t ctl;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int seed = 29214;
	int mem[512];
	int pb[16] = '{default: -1};
	int pg, off, r, a2;
	always #12.5 clk_sys = ~clk_sys;
	always #170 slow_clk = ~slow_clk;
	eedp_core_model core (.clk_sys(clk_sys), .ptr1_high_wr(p1w),
		.addr_high_wr(ahw), .addr_low_wr(alw), .data_wr(dw), .ind_wr(iw),
		.wdata(wd), .global_irq_enable(gie));
	eedp_ctrl #(.TICKS(TK)) dut (.clk_sys(clk_sys), .rst(rst),
		.slow_clk(slow_clk), .ptr1_high_wr(p1w), .ptr2_high_wr(1'b0),
		.ptr_wdata(wd), .pointer1_low_byte(CTL_OFFSET),
		.ptr2_low_byte(8'h00), .ind_wr(iw), .ind_sel(1'b0),
		.ind_wdata(wd), .addr_high_wr(ahw), .addr_low_wr(alw),
		.data_wr(dw), .reg_wdata(wd), .global_irq_enable(gie),
		.eeprom_irq_enable(eie), .stack_full(stack_full),
		.irq_service(irq_service), .pointer1_high_byte(p1h),
		.pointer2_high_byte(p2hb), .eeprom_control_reg(ctl),
		.eeprom_addr_high_reg(ahr), .eeprom_addr_low_reg(al),
		.eeprom_data_reg(dat), .eeprom_irq_flag(irq_flag),
		.irq_request(irq_req));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("mismatches %0d of %0d checks", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			conclude;
		end
	end
	// bounded poll until the masked control bits drop
	task automatic wait_clr(input logic [7:0] m);
		for (int n = 0; n < 4000 && (ctl & m) != 8'h00; n++)
			@(negedge clk_sys);
		check(ctl & m, 16'h0000);
	endtask
	task automatic run(input logic [7:0] en, input logic [7:0] go);
		// drop any stale flag so the flag check below means something
		irq_service <= 1'b1;
		@(negedge clk_sys);
		irq_service <= 1'b0;
		core.start(en, go);
		@(negedge clk_sys);
		check(ctl & go & 8'h24, go & 8'h24);
		wait_clr(8'h24);
		check(ctl & 8'hEF, 16'h0000);
		check(irq_flag, 16'h0001);
	endtask
	task automatic addr(input int a);
		core.wr(1, 8'(a >> 8));
		core.wr(2, 8'(a));
		off = a & 15;
	endtask
	// load n bytes, modelling the stop at offset F
	task automatic load(input int n);
		for (int k = 0; k < n; k++) begin
			r = $random(seed) & 8'hFF;
			core.wr(3, 8'(r));
			if (off <= 15)
				pb[off] = r;
			off = (off < 15) ? off + 1 : 16;
		end
		core.wr(5, 8'h00);
		@(negedge clk_sys);
		check(al, {pg[3:0], off > 15 ? 4'hF : 4'(off)});
		check(ahr, pg[4]);
	endtask
	task automatic commit(input bit erase);
		for (int k = 0; k < 16; k++)
			if (pb[k] >= 0)
				mem[pg * 16 + k] = erase ? 0 : pb[k];
		pb = '{default: -1};
	endtask
	task automatic rd(input int a);
		core.wr(4, ctl | 8'h01);
		core.wr(5, 8'h00);
		wait_clr(8'h01);
		check(dat, mem[a]);
	endtask
	initial begin
		repeat (16) @(negedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		check(ctl, 16'h0000);
		check(p1h, PTR_RESET);
		check(p2hb, PTR_RESET);
		core.wr(4, 8'h10);
		core.wr(5, 8'h00);
		@(negedge clk_sys);
		check(ctl, 16'h0000);
		core.wr(0, CTL_SECTOR);
		core.wr(4, 8'h14);
		core.wr(5, 8'h00);
		@(negedge clk_sys);
		check(ctl, 16'h0010);
		pg = $random(seed) & 31;
		// erase the page before any page write to it
		addr(pg * 16);
		load(16);
		run(8'h50, 8'h70);
		commit(1'b1);
		stack_full <= 1'b1;
		repeat (2) @(negedge clk_sys);
		check(irq_req, 16'h0000);
		stack_full <= 1'b0;
		repeat (2) @(negedge clk_sys);
		check(irq_req, 16'h0001);
		irq_service <= 1'b1;
		@(negedge clk_sys);
		irq_service <= 1'b0;
		@(negedge clk_sys);
		check(irq_flag, 16'h0000);
		addr(pg * 16);
		load(17);
		// strobe a cycle late must not start; enable fall drops buffer
		core.wr(4, 8'h18);
		core.wr(5, 8'h00);
		core.wr(4, 8'h1C);
		core.wr(5, 8'h00);
		@(negedge clk_sys);
		check(ctl, 16'h0018);
		core.wr(4, 8'h10);
		pb = '{default: -1};
		addr(pg * 16);
		load(8);
		run(8'h18, 8'h1C);
		commit(1'b0);
		core.wr(4, 8'h12);
		addr(pg * 16);
		for (int i = 0; i < 17; i++) begin
			rd(pg * 16 + (i > 15 ? 15 : i));
			check(al, {pg[3:0], i >= 14 ? 4'hF : 4'(i + 1)});
		end
		a2 = (pg * 16 + 21) & 511;
		core.wr(4, 8'h00);
		addr(a2);
		r = $random(seed) & 8'hFF;
		core.wr(3, 8'(r));
		run(8'h08, 8'h0C);
		mem[a2] = r;
		core.wr(4, 8'h02);
		rd(a2);
		check(al, 8'(a2));
		conclude;
	end
endmodule
